// >>> sar_mem_model.sv
// Memory partner: word store with ready stretching, byte parity and bus grant
module sar_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] mem_addr,
  input wire logic mem_strobe_n,
  input wire logic mem_write,
  input wire logic [31:0] mem_data_o,
  input wire logic [3:0] mem_par_o,
  input wire logic mem_data_oe,
  input wire logic bus_request,
  input wire logic odd,
  input wire logic flip,
  input wire logic [3:0] wait_cyc,
  output logic [31:0] mem_data_i,
  output logic [3:0] mem_par_i,
  output logic mem_ready_n,
  output logic bus_grant,
  output logic par_bad
);
  logic [31:0] mem_q [64];
  logic [31:0] last_q;
  logic [3:0] cnt_q;
  logic [3:0] hold_q;
  logic [3:0] par_w;
  logic [3:0] wpar_w;
  // Byte parity of the stored word and of the word being written
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      par_w[i] = ^mem_q[mem_addr[7:2]][8*i+:8] ^ odd;
      wpar_w[i] = ^mem_data_o[8*i+:8] ^ odd;
    end
  end
  // Ready withheld for wait_cyc clocks of each cycle
  assign mem_ready_n = (cnt_q < wait_cyc);
  // Read data held a few clocks for the input flops, then inverted so stale data never matches
  assign mem_data_i = (hold_q != 4'h0) ? mem_q[mem_addr[7:2]] : ~last_q;
  assign mem_par_i = (hold_q != 4'h0) ? (par_w ^ {4{flip}}) : ~par_w;
  // Stretch count, hold window, write capture and grant
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      hold_q <= 4'h0;
      last_q <= 32'h0;
      bus_grant <= 1'b0;
      par_bad <= 1'b0;
    end else begin
      cnt_q <= mem_strobe_n ? 4'h0 : cnt_q + 4'h1;
      hold_q <= (!mem_strobe_n && !mem_write) ? 4'h4 : ((hold_q != 4'h0) ? hold_q - 4'h1 : 4'h0);
      if (hold_q != 4'h0) last_q <= mem_q[mem_addr[7:2]];
      bus_grant <= bus_request;
      if (!mem_strobe_n && mem_write && mem_data_oe) begin
        mem_q[mem_addr[7:2]] <= mem_data_o;
        if (mem_par_o !== wpar_w) par_bad <= 1'b1;
      end
    end
  end
endmodule : sar_mem_model

// >>> sar_memory_dma_interface.sv
// Module: SAR memory bus master with APB control, parity, strobes and transmit circuit cache
// Operation
// - Two selectable bus conventions, each with its own read and write cycles; here both share one cycle set and C_CONV only forces big endian.
// - Extended variant bursts one data word per clock.
// - First convention selects little or big endian; second is always big endian.
// - Each DMA tenure is limited to 1..255 memory cycles, then the bus is released.
// - In ready-dependent mode a cycle waits until ready is asserted.
// - In fast cycle mode a ready transition raises a contention interrupt.
// - DMA mode arbitrates for the bus first; dual-port mode drives directly.
// - Strap tied low selects address drive mode; otherwise a register bit decides.
// - Ready is sampled at the end of cycle state 3.
// - Asynchronous ready passes an extra synchroniser stage, one clock later.
// - Four start-of-cycle outputs: tx overhead, tx data, rx overhead, rx data.
// - Normal mode asserts start-of-cycle one clock before the operation.
// - Ready-dependent back-to-back cycles assert the next strobe in the second clock.
// - With stealing or grouping one strobe may precede a run of same-type cycles.
// - Parity generated on writes and checked on reads, one bit per byte.
// - A configuration bit selects odd or even parity.
// - Parity error raises an unmaskable interrupt; data is still delivered whole.
// - Ordering field: 0 legacy, 1 data steal, 7 data+overhead steal, 1F grouped.
// - On-chip cache holds parameters of up to 128 circuits.
// - First use fetches and stores parameters; later uses work from the copy.
// - Cache entries stay valid after completion until replaced or invalidated.
module sar_memory_dma_interface #(
  parameter int CACHE_DEPTH = 128
) (
  input logic pclk,
  input logic presetn,
  input logic [7:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic req_valid,
  input sarm_pkg::mreq_s req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_data,
  output logic [31:0] mem_addr,
  output logic mem_addr_oe,
  output logic mem_strobe_n,
  output logic mem_burst_n,
  output logic mem_write,
  input logic [31:0] mem_data_i,
  output logic [31:0] mem_data_o,
  output logic mem_data_oe,
  input logic [3:0] mem_par_i,
  output logic [3:0] mem_par_o,
  output logic mem_par_oe,
  input logic mem_ready_n,
  output logic bus_request,
  input logic bus_grant,
  input logic address_drive_strap_n,
  output logic tx_overhead_cycle_start,
  output logic tx_data_cycle_start,
  output logic rx_overhead_cycle_start,
  output logic rx_data_cycle_start,
  output logic parity_irq,
  output logic contention_irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  sarm_pkg::mst_e st_q, st_d;
  sarm_pkg::mreq_s cur_q;
  logic [31:0] ctrl_q;
  logic [4:0] ord_q;
  logic [7:0] cnt_q;
  logic perr_q, cont_q, skip_q, socd_q, brst_q;
  logic rsp_valid_q;
  logic [31:0] rsp_data_q, prdata_q, rd_val;
  logic rdy_s1, rdy_s2, rdy_s3, gnt_s1, gnt_s2, strap_s1, strap_s2;
  logic [31:0] dat_s1, dat_s2;
  logic [3:0] par_s1, par_s2, perr_v, soc_vec;
  logic [CACHE_DEPTH-1:0] cvld_q;
  logic [31:0] cpar_q [CACHE_DEPTH];
  logic done;

  function automatic logic [31:0] swap32(input logic [31:0] d);
    swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction : swap32

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire conv2 = ctrl_q[sarm_pkg::C_CONV];
  wire ext = ctrl_q[sarm_pkg::C_EXT];
  wire swap_on = conv2 | ctrl_q[sarm_pkg::C_BIG];
  wire rdep = ctrl_q[sarm_pkg::C_RDEP];
  wire dma = ctrl_q[sarm_pkg::C_DMA];
  wire odd = ctrl_q[sarm_pkg::C_ODD];
  wire [7:0] lim_raw = ctrl_q[sarm_pkg::C_LIM+:8];
  // A zero limit would stall forever, so it acts as one cycle
  wire [7:0] lim = (lim_raw == 8'h00) ? 8'h01 : lim_raw;
  // Strap wins when tied low; its pull-up hands control to software
  wire drive_on = !strap_s2 | ctrl_q[sarm_pkg::C_DRV];

  wire st_idle = (st_q == sarm_pkg::ST_IDLE);
  wire st_arb = (st_q == sarm_pkg::ST_ARB);
  wire st_soc = (st_q == sarm_pkg::ST_SOC);
  wire st_t2 = (st_q == sarm_pkg::ST_T2);
  wire st_t3 = (st_q == sarm_pkg::ST_T3);
  wire st_t4 = (st_q == sarm_pkg::ST_T4);
  wire in_cyc = (st_q == sarm_pkg::ST_T1) | st_t2 | st_t3;
  wire active = in_cyc | st_t4;

  // ----------------------------------------
  // Ready, grant, strap and data synchronisers
  // ----------------------------------------
  // Async ready takes a third stage, costing one clock of latency
  wire rdy_eff = ctrl_q[sarm_pkg::C_ASYNC] ? rdy_s3 : rdy_s2;
  wire wait_rdy = rdep & !rdy_eff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
      rdy_s3 <= 1'b0;
      gnt_s1 <= 1'b0;
      gnt_s2 <= 1'b0;
      strap_s1 <= 1'b1;
      strap_s2 <= 1'b1;
    end else begin
      rdy_s1 <= !mem_ready_n;
      rdy_s2 <= rdy_s1;
      rdy_s3 <= rdy_s2;
      gnt_s1 <= bus_grant;
      gnt_s2 <= gnt_s1;
      strap_s1 <= address_drive_strap_n;
      strap_s2 <= strap_s1;
    end
  end

  // Read data and parity pins, sampled alongside ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat_s1 <= 32'h0000_0000;
      dat_s2 <= 32'h0000_0000;
      par_s1 <= 4'h0;
      par_s2 <= 4'h0;
    end else begin
      dat_s1 <= mem_data_i;
      dat_s2 <= dat_s1;
      par_s1 <= mem_par_i;
      par_s2 <= par_s1;
    end
  end

  // ----------------------------------------
  // Request classification
  // ----------------------------------------
  // Cached parameter reads are marked by the caller per circuit
  wire hit = req_valid & req.cached & (req.kind == sarm_pkg::K_TXO) & !req.wr
    & cvld_q[req.circ];
  wire same = (req.kind == cur_q.kind) & (req.wr == cur_q.wr);
  // Data kinds steal from the 1H setting, overhead from 7H, grouping at 1FH
  wire steal = req.kind[0] ? (ord_q[sarm_pkg::ORD_DSTEAL] | ord_q[sarm_pkg::ORD_GROUP])
    : (ord_q[sarm_pkg::ORD_OSTEAL] | ord_q[sarm_pkg::ORD_GROUP]);
  wire soc_skip = brst_q & (req.kind == cur_q.kind) & steal;
  wire [7:0] cnt_nx = cnt_q + 8'h01;
  wire more_ok = !dma | (cnt_nx < lim);
  wire brst_ok = ext & same & more_ok & !hit;
  wire next_ok = req_valid & !hit & more_ok;
  wire t2_soc = st_t2 & rdep & next_ok & !brst_ok & !soc_skip;

  // ----------------------------------------
  // Cycle state machine
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    req_ready = 1'b0;
    done = 1'b0;
    case (st_q)
      sarm_pkg::ST_IDLE: begin
        // A grant still standing from the last tenure is stale; wait for it to drop first
        if (req_valid & !(dma & gnt_s2)) begin
          req_ready = 1'b1;
          if (hit) begin
            st_d = sarm_pkg::ST_IDLE;
          end else if (dma & !gnt_s2) begin
            st_d = sarm_pkg::ST_ARB;
          end else if (soc_skip) begin
            st_d = sarm_pkg::ST_T1;
          end else begin
            st_d = sarm_pkg::ST_SOC;
          end
        end
      end
      sarm_pkg::ST_ARB: begin
        if (gnt_s2) begin
          st_d = skip_q ? sarm_pkg::ST_T1 : sarm_pkg::ST_SOC;
        end
      end
      sarm_pkg::ST_SOC: st_d = sarm_pkg::ST_T1;
      sarm_pkg::ST_T1: st_d = sarm_pkg::ST_T2;
      sarm_pkg::ST_T2: st_d = sarm_pkg::ST_T3;
      sarm_pkg::ST_T3: begin
        // Ready is looked at here, the end of state 3, and in T4 only to hold extended bursts
        if (!wait_rdy) begin
          st_d = sarm_pkg::ST_T4;
        end
      end
      sarm_pkg::ST_T4: begin
        done = 1'b1;
        if (next_ok) begin
          req_ready = 1'b1;
          if (brst_ok) begin
            st_d = sarm_pkg::ST_T4;
          end else if (soc_skip | socd_q) begin
            st_d = sarm_pkg::ST_T1;
          end else begin
            st_d = sarm_pkg::ST_SOC;
          end
        end else begin
          st_d = sarm_pkg::ST_IDLE;
        end
      end
      default: st_d = sarm_pkg::ST_IDLE;
    endcase
  end

  // Burst words hold in T4 while ready-dependent memory is not ready
  wire burst_hold = st_t4 & brst_q & ext & wait_rdy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= sarm_pkg::ST_IDLE;
    end else if (!burst_hold) begin
      st_q <= st_d;
    end
  end

  // Current request and tenure bookkeeping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_q <= '0;
      cnt_q <= 8'h00;
      skip_q <= 1'b0;
      socd_q <= 1'b0;
      brst_q <= 1'b0;
    end else if (!burst_hold) begin
      if (req_ready) begin
        cur_q <= req;
        skip_q <= soc_skip;
      end
      if (st_idle) begin
        cnt_q <= 8'h00;
      end else if (done) begin
        cnt_q <= cnt_nx;
      end
      if (st_t2) begin
        socd_q <= t2_soc;
      end else if (st_t4) begin
        socd_q <= 1'b0;
      end
      if (done) begin
        brst_q <= 1'b1;
      end else if (st_idle) begin
        brst_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Memory bus pins
  // ----------------------------------------
  assign bus_request = dma & !st_idle;
  assign mem_addr = cur_q.addr;
  assign mem_write = cur_q.wr;
  assign mem_strobe_n = !(in_cyc | (st_t4 & brst_q & ext));
  assign mem_burst_n = !(st_t4 & ext & brst_ok);
  // Dual-port mode with drive selected keeps the lines driven when idle
  assign mem_addr_oe = active | (drive_on & !dma);
  assign mem_data_o = swap_on ? swap32(cur_q.data) : cur_q.data;
  assign mem_data_oe = active & cur_q.wr;
  assign mem_par_oe = active & cur_q.wr;

  // Per-byte parity out and check in
  genvar g;
  for (g = 0; g < 4; g++) begin : g_par
    assign mem_par_o[g] = (^mem_data_o[8*g+:8]) ^ odd;
    assign perr_v[g] = (^{dat_s2[8*g+:8], par_s2[g]}) ^ odd;
  end

  // ----------------------------------------
  // Start-of-cycle strobes
  // ----------------------------------------
  wire soc_now = st_soc | t2_soc;
  wire [1:0] soc_kind = st_soc ? cur_q.kind : req.kind;
  for (g = 0; g < 4; g++) begin : g_soc
    assign soc_vec[g] = soc_now & (soc_kind == 2'(g));
  end
  assign tx_overhead_cycle_start = soc_vec[0];
  assign tx_data_cycle_start = soc_vec[1];
  assign rx_overhead_cycle_start = soc_vec[2];
  assign rx_data_cycle_start = soc_vec[3];

  // ----------------------------------------
  // Read answers and transmit cache
  // ----------------------------------------
  wire rd_done = done & !burst_hold & !cur_q.wr;
  wire [31:0] rd_word = swap_on ? swap32(dat_s2) : dat_s2;
  wire hit_take = st_idle & hit & req_ready;
  wire fill = done & !burst_hold & cur_q.cached & (cur_q.kind == sarm_pkg::K_TXO);
  wire [31:0] fill_word = cur_q.wr ? cur_q.data : rd_word;
  wire cinv_wr = psel & penable & pwrite & (paddr == sarm_pkg::CINV_OFF);
  wire inv_all = cinv_wr & pwdata[sarm_pkg::CINV_ALL];
  wire [sarm_pkg::CIRC_W-1:0] inv_idx = pwdata[sarm_pkg::CIRC_W-1:0];

  // Data is delivered even on a parity error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 32'h0000_0000;
    end else begin
      rsp_valid_q <= rd_done | hit_take;
      if (hit_take) begin
        rsp_data_q <= cpar_q[req.circ];
      end else if (rd_done) begin
        rsp_data_q <= rd_word;
      end
    end
  end
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;

  // One entry per circuit; a fill beats an invalidate in the same cycle
  for (g = 0; g < CACHE_DEPTH; g++) begin : g_cache
    wire me_fill = fill & (cur_q.circ == sarm_pkg::CIRC_W'(g));
    wire me_inv = inv_all | (cinv_wr & (inv_idx == sarm_pkg::CIRC_W'(g)));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cvld_q[g] <= 1'b0;
        cpar_q[g] <= 32'h0000_0000;
      end else if (me_fill) begin
        cvld_q[g] <= 1'b1;
        cpar_q[g] <= fill_word;
      end else if (me_inv) begin
        cvld_q[g] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // APB registers
  // ----------------------------------------
  wire wr_en = psel & penable & pwrite;
  wire a_ctrl = (paddr == sarm_pkg::CTRL_OFF);
  wire a_ord = (paddr == sarm_pkg::ORD_OFF);
  wire a_stat = (paddr == sarm_pkg::STAT_OFF);
  wire a_cinv = (paddr == sarm_pkg::CINV_OFF);
  wire perr_set = rd_done & (|perr_v);
  wire cont_set = !rdep & (rdy_s2 ^ rdy_s3);
  wire stat_wr = wr_en & a_stat;

  always_comb begin
    if (a_ctrl) begin
      rd_val = ctrl_q;
    end else if (a_ord) begin
      rd_val = {11'h000, ord_q, 16'h0000};
    end else if (a_stat) begin
      rd_val = {27'h000_0000, !strap_s2, !st_idle, gnt_s2, cont_q, perr_q};
    end else begin
      rd_val = 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= sarm_pkg::CTRL_RST;
      ord_q <= sarm_pkg::ORD_RST;
      prdata_q <= 32'h0000_0000;
    end else begin
      if (wr_en & a_ctrl) begin
        ctrl_q <= pwdata;
      end
      if (wr_en & a_ord) begin
        ord_q <= pwdata[sarm_pkg::ORD_LSB+:5];
      end
      if (psel & !penable) begin
        prdata_q <= rd_val;
      end
    end
  end

  // Sticky flags: write one clears, a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr_q <= 1'b0;
      cont_q <= 1'b0;
    end else begin
      perr_q <= perr_set | (perr_q & !(stat_wr & pwdata[sarm_pkg::S_PERR]));
      cont_q <= cont_set | (cont_q & !(stat_wr & pwdata[sarm_pkg::S_CONT]));
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & !(a_ctrl | a_ord | a_stat | a_cinv);
  // Parity interrupt has no mask by design
  assign parity_irq = perr_q;
  assign contention_irq = cont_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence soc_then_op;
    st_soc && (soc_vec != 4'h0) ##1 (st_q == sarm_pkg::ST_T1) ##1 st_t2;
  endsequence

  soc_lead_a: assert property (st_soc |-> soc_then_op)
    else $error("start strobe not one clock before cycle");
  grant_first_a: assert property (dma && active |-> gnt_s2)
    else $error("cycle driven without bus grant");
  ready_wait_a: assert property (st_t3 && wait_rdy |=> st_t3 && !mem_strobe_n)
    else $error("cycle completed without ready");
  burst_cap_a: assert property (dma && active |-> cnt_q < lim)
    else $error("burst exceeded programmed limit");
  release_a: assert property (dma && st_t4 && !more_ok |=> st_idle ##1 !bus_request)
    else $error("bus not released at burst limit");
  parity_flag_a: assert property (perr_set |=> perr_q && parity_irq ##1 rsp_data == $past(rd_word, 2))
    else $error("parity error not flagged or data lost");
  contention_a: assert property (!rdep && $changed(rdy_s3) |-> contention_irq)
    else $error("ready transition not flagged");
  async_lag_a: assert property (ctrl_q[sarm_pkg::C_ASYNC] |-> rdy_eff == $past(rdy_s2))
    else $error("async ready not delayed one clock");
  par_gen_a: assert property (mem_par_oe |-> (^{mem_data_o[31:24], mem_par_o[3]}) == odd)
    else $error("generated parity wrong");
  cache_hit_a: assert property (hit_take |=> rsp_valid && !active)
    else $error("cached parameter read went to memory");
endmodule : sar_memory_dma_interface

// >>> sar_memory_dma_interface_tb_top.sv
// Testbench: APB set-up, memory requests against the partner model, scoreboard and verdict
module sar_memory_dma_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, req_valid = 1'b0, odd = 1'b0, flip = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rsp_data, mem_addr, mem_data_i, mem_data_o, rdv, d, e;
  logic pready, pslverr, req_ready, rsp_valid, mem_addr_oe, mem_strobe_n, mem_burst_n, mem_write;
  logic mem_data_oe, mem_par_oe, mem_ready_n, bus_request, bus_grant, par_bad, parity_irq, contention_irq;
  logic address_drive_strap_n = 1'b1, burst_seen = 1'b0, req_d = 1'b0, last_err, quiet = 1'b0;
  logic tx_overhead_cycle_start, tx_data_cycle_start, rx_overhead_cycle_start, rx_data_cycle_start;
  logic [3:0] mem_par_i, mem_par_o, wait_cyc = 4'h0;
  logic [31:0] dv [4];
  logic [4:0] ords [4] = '{5'h00, 5'h01, 5'h07, 5'h1F};
  sarm_pkg::mreq_s req = '0;
  logic [31:0] expq [$];
  int failures = 0, n_checks = 0, rises = 0, cyc = 0, lat, l0, c0;
  int soc_n [4] = '{0, 0, 0, 0};
  int l3 [2];
  integer seed = 32'h598E3D8B;
  sar_memory_dma_interface uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .req_valid, .req, .req_ready, .rsp_valid, .rsp_data, .mem_addr, .mem_addr_oe, .mem_strobe_n,
    .mem_burst_n, .mem_write, .mem_data_i, .mem_data_o, .mem_data_oe, .mem_par_i, .mem_par_o, .mem_par_oe,
    .mem_ready_n, .bus_request, .bus_grant, .address_drive_strap_n, .tx_overhead_cycle_start,
    .tx_data_cycle_start, .rx_overhead_cycle_start, .rx_data_cycle_start, .parity_irq, .contention_irq);
  sar_mem_model mem (.pclk, .presetn, .mem_addr, .mem_strobe_n, .mem_write, .mem_data_o, .mem_par_o,
    .mem_data_oe, .bus_request, .odd, .flip, .wait_cyc, .mem_data_i, .mem_par_i, .mem_ready_n, .bus_grant,
    .par_bad);
  // 250 MHz clock
  always #2 pclk = ~pclk;
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  // Scoreboard, counters, idle flag and hang limit; read mid-cycle so registered outputs have settled
  always @(negedge pclk) begin
    cyc++;
    if (rsp_valid === 1'b1) chk(rsp_data, (expq.size() != 0) ? expq.pop_front() : ~rsp_data);
    soc_n[0] += (tx_overhead_cycle_start === 1'b1);
    soc_n[1] += (tx_data_cycle_start === 1'b1);
    soc_n[2] += (rx_overhead_cycle_start === 1'b1);
    soc_n[3] += (rx_data_cycle_start === 1'b1);
    if (mem_burst_n === 1'b0) burst_seen = 1'b1;
    if (bus_request === 1'b1 && req_d !== 1'b1) rises++;
    req_d = bus_request;
    // Idle: nothing owed, no strobe, no address drive, no bus request
    quiet = expq.size() == 0 && mem_strobe_n === 1'b1 && mem_addr_oe !== 1'b1 && bus_request !== 1'b1
      && {tx_overhead_cycle_start, tx_data_cycle_start, rx_overhead_cycle_start, rx_data_cycle_start} === 4'h0;
    if (cyc == 40000) begin
      failures++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Bus tasks: APB master and memory request driver
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Holds valid until taken; wt=0 keeps it up so the next request follows at once
  task automatic mreq(input logic [1:0] k, input logic w, input logic c, input logic [5:0] ix,
                      input logic [31:0] wd, input logic [31:0] ex, input bit wt);
    logic tk;
    req_valid <= 1'b1;
    req <= '{kind: k, wr: w, cached: c, circ: 7'h7F, addr: {24'h0, ix, 2'b00}, data: wd};
    // Ready is looked at mid-cycle; at the edge itself the state may already have moved on
    do begin
      @(negedge pclk);
      tk = req_ready;
      @(posedge pclk);
    end while (tk !== 1'b1);
    if (!w) expq.push_back(ex);
    if (wt) begin
      req_valid <= 1'b0;
      lat = 0;
      do begin
        @(posedge pclk);
        lat++;
      end while (quiet !== 1'b1);
    end
  endtask : mreq
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, sarm_pkg::CTRL_OFF, 32'h0);
    chk(rdv, 32'h0000_FF08);
    apb(1'b0, 8'h20, 32'h0);
    chk(last_err, 32'h1);
    foreach (ords[i]) begin
      apb(1'b1, sarm_pkg::ORD_OFF, {11'h0, ords[i], 16'h0});
      apb(1'b0, sarm_pkg::ORD_OFF, 32'h0);
      chk(rdv, {11'h0, ords[i], 16'h0});
    end
    apb(1'b1, sarm_pkg::ORD_OFF, 32'h0);
    // Every access kind: write then read back, one strobe each
    for (int k = 0; k < 4; k++) begin
      dv[k] = $random(seed);
      mreq(2'(k), 1'b1, 1'b0, 6'(k + 1), dv[k], 32'h0, 1'b1);
      mreq(2'(k), 1'b0, 1'b0, 6'(k + 1), 32'h0, dv[k], 1'b1);
      chk(soc_n[k], 32'h2);
    end
    // Stretched cycles, synchronous then asynchronous ready
    for (int a = 0; a < 2; a++) begin
      apb(1'b1, sarm_pkg::CTRL_OFF, a ? 32'h0000_FF18 : 32'h0000_FF08);
      wait_cyc <= 4'h0;
      mreq(2'h1, 1'b0, 1'b0, 6'h2, 32'h0, dv[1], 1'b1);
      l0 = lat;
      wait_cyc <= 4'h3;
      mreq(2'h1, 1'b0, 1'b0, 6'h2, 32'h0, dv[1], 1'b1);
      l3[a] = lat;
      chk(l3[a] >= l0 + 3, 32'h1);
    end
    chk(l3[1], l3[0] + 1);
    // Big endian under the first convention, and the second convention
    wait_cyc <= 4'h0;
    e = {<<8{dv[1]}};
    apb(1'b1, sarm_pkg::CTRL_OFF, 32'h0000_FF0C);
    mreq(2'h1, 1'b0, 1'b0, 6'h2, 32'h0, e, 1'b1);
    apb(1'b1, sarm_pkg::CTRL_OFF, 32'h0000_FF09);
    mreq(2'h1, 1'b0, 1'b0, 6'h2, 32'h0, e, 1'b1);
    // Odd parity, then a corrupted read that must still deliver the word
    apb(1'b1, sarm_pkg::CTRL_OFF, 32'h0000_FF88);
    odd <= 1'b1;
    d = $random(seed);
    mreq(2'h3, 1'b1, 1'b0, 6'h5, d, 32'h0, 1'b1);
    mreq(2'h3, 1'b0, 1'b0, 6'h5, 32'h0, d, 1'b1);
    chk({parity_irq, par_bad}, 32'h0);
    flip <= 1'b1;
    mreq(2'h3, 1'b0, 1'b0, 6'h5, 32'h0, d, 1'b1);
    chk(parity_irq, 32'h1);
    flip <= 1'b0;
    apb(1'b1, sarm_pkg::STAT_OFF, 32'h1);
    @(posedge pclk);
    chk(parity_irq, 32'h0);
    // Fast cycles: a steady ready is quiet, a moving one raises contention
    apb(1'b1, sarm_pkg::CTRL_OFF, 32'h0000_FF00);
    odd <= 1'b0;
    mreq(2'h3, 1'b0, 1'b0, 6'h5, 32'h0, d, 1'b1);
    chk(contention_irq, 32'h0);
    wait_cyc <= 4'h2;
    mreq(2'h3, 1'b0, 1'b0, 6'h5, 32'h0, d, 1'b1);
    chk(contention_irq, 32'h1);
    wait_cyc <= 4'h0;
    // DMA tenures with burst limit 1 and 255, extended bursts
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, sarm_pkg::CTRL_OFF, m ? 32'h0000_FF2A : 32'h0000_012A);
      rises = 0;
      burst_seen = 1'b0;
      for (int j = 0; j < 3; j++) mreq(2'h1, 1'b1, 1'b0, 6'(8 + j), dv[j], 32'h0, j == 2);
      chk(rises, m ? 32'h1 : 32'h3);
      if (m) chk(burst_seen, 32'h1);
      mreq(2'h1, 1'b0, 1'b0, 6'hA, 32'h0, dv[2], 1'b1);
    end
    // Cached circuit: hit without a bus cycle, then invalidate
    apb(1'b1, sarm_pkg::CTRL_OFF, 32'h0000_FF08);
    c0 = soc_n[0];
    mreq(2'h0, 1'b0, 1'b1, 6'h1, 32'h0, dv[0], 1'b1);
    mreq(2'h0, 1'b0, 1'b1, 6'h1, 32'h0, dv[0], 1'b1);
    chk(soc_n[0], c0 + 1);
    apb(1'b1, sarm_pkg::CINV_OFF, 32'h0000_0100);
    mreq(2'h0, 1'b0, 1'b1, 6'h1, 32'h0, dv[0], 1'b1);
    chk(soc_n[0], c0 + 2);
    // Back-to-back reads: next strobe in the second clock, then data stealing folds the third
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, sarm_pkg::ORD_OFF, {11'h0, ords[s], 16'h0});
      c0 = soc_n[1];
      for (int j = 0; j < 3; j++) mreq(2'h1, 1'b0, 1'b0, 6'(8 + j), 32'h0, dv[j], j == 2);
      chk(soc_n[1], c0 + 3 - s);
    end
    // Strap low drives the address lines even when idle
    address_drive_strap_n <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, sarm_pkg::STAT_OFF, 32'h0);
    chk({rdv[4], mem_addr_oe}, 32'h3);
    print_verdict();
  end
endmodule : sar_memory_dma_interface_tb_top

// >>> sarm_pkg.sv
// Package: register map, field layout, states and request carrier of the SAR memory interface
package sarm_pkg;
  // ----------------------------------------
  // Register offsets (APB byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] ORD_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] CINV_OFF = 8'h0C;

  // Control register fields
  localparam int C_CONV = 0;
  localparam int C_EXT = 1;
  localparam int C_BIG = 2;
  localparam int C_RDEP = 3;
  localparam int C_ASYNC = 4;
  localparam int C_DMA = 5;
  localparam int C_DRV = 6;
  localparam int C_ODD = 7;
  localparam int C_LIM = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_FF08;

  // Cycle ordering field, upper word of the ordering register
  localparam int ORD_LSB = 16;
  localparam int ORD_DSTEAL = 0;
  localparam int ORD_OSTEAL = 2;
  localparam int ORD_GROUP = 4;
  localparam logic [4:0] ORD_RST = 5'h00;

  // Status and cache-invalidate fields
  localparam int S_PERR = 0;
  localparam int S_CONT = 1;
  localparam int CINV_ALL = 8;
  localparam int CIRC_W = 7;

  // Access kinds, also the start-of-cycle strobe index
  localparam logic [1:0] K_TXO = 2'h0;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_ARB = 7'h02, ST_SOC = 7'h04, ST_T1 = 7'h08,
    ST_T2 = 7'h10, ST_T3 = 7'h20, ST_T4 = 7'h40
  } mst_e;

  typedef struct packed {
    logic [1:0] kind;
    logic wr;
    logic cached;
    logic [CIRC_W-1:0] circ;
    logic [31:0] addr;
    logic [31:0] data;
  } mreq_s;
endpackage : sarm_pkg
